// File: iad_front.sv
// Expansion-bus slave address/data pin front end: upper address latch, window
// decode, byte-lane steering, pin reuse in 8-bit mode and the mode strap.
// Assumes all pins are asynchronous to clk and commands last several cycles.
// Behaviour
// RULE1 - Host bus mode is selected when the write/strap pin reads high at reset release.
// RULE2 - The bus address is the seven latched upper lines over the seventeen static lines.
// RULE3 - Address pins are only ever inputs and are never driven.
// RULE4 - Unused upper address pins serve as five interrupt inputs or four port A bits.
// RULE5 - Upper address bits given to another function read as zero in the address path.
// RULE6 - Upper address lines are captured at the trailing edge of the latch enable.
// RULE7 - The master keeps the static address stable through each command.
// RULE8 - 16-bit mode uses all sixteen data lines, 8-bit mode only the low eight.
// RULE9 - Data lines are driven only in read cycles and only received in write cycles.
// RULE10 - In 8-bit mode data lines eight to ten carry three host interrupt outputs.
// RULE11 - The low byte travels on the low lane when address bit zero is low; 8-bit uses it always.
// RULE12 - In 16-bit mode the high byte travels on the high lane only with high enable asserted.
// RULE13 - Addresses and commands are answered only while address enable is low.
// RULE14 - The data bus is never driven while refresh is active; the code still drives interrupt lines eight to ten in 8-bit mode.
// RULE15 - A command is served only when its address falls in the device window.
// RULE16 - Channel ready is pulled low to stretch a cycle while the core needs wait states.
// RULE17 - In 8-bit mode high enable is ignored and every access is one byte on the low lane.
module iad_front #(
    parameter int SD_W = iad_pkg::IAD_SD_W,
    parameter int SA_W = iad_pkg::IAD_SA_W,
    parameter int LA_W = iad_pkg::IAD_LA_W
) (
    input  wire logic                                clk,
    input  wire logic                                rst_n,
    input  wire logic [iad_pkg::IAD_LA_W-1:0]        la_pin,
    input  wire logic [iad_pkg::IAD_SA_W-1:0]        sa_pin,
    input  wire logic [iad_pkg::IAD_SD_W-1:0]        sd_in,
    output logic      [iad_pkg::IAD_SD_W-1:0]        sd_out,
    output logic      [iad_pkg::IAD_SD_W-1:0]        sd_oe,
    input  wire logic                                bale,
    input  wire logic                                aen,
    input  wire logic                                sbhe_n,
    input  wire logic                                memr_n,
    input  wire logic                                memw_n,
    input  wire logic                                ior_n,
    input  wire logic                                iow_card_interface_strap_n,
    input  wire logic                                ref_n,
    output logic                                     iochrdy_out,
    output logic                                     iochrdy_oe,
    input  wire logic                                cfg_bus16,
    input  wire iad_pkg::iad_ua_mode_t               cfg_ua_mode,
    input  wire logic [iad_pkg::IAD_ADDR_W-1:0]      cfg_mem_base,
    input  wire logic [iad_pkg::IAD_ADDR_W-1:0]      cfg_mem_mask,
    input  wire logic [iad_pkg::IAD_SA_W-1:0]        cfg_io_base,
    input  wire logic [iad_pkg::IAD_SA_W-1:0]        cfg_io_mask,
    input  wire logic [iad_pkg::IAD_IRQ_W-1:0]       host_irq_req,
    input  wire logic                                core_wait,
    input  wire logic [iad_pkg::IAD_SD_W-1:0]        core_rdata,
    output iad_pkg::iad_access_t                     acc,
    output logic                                     acc_valid,
    output logic [iad_pkg::IAD_ALT_W-1:0]            external_interrupt_inputs,
    output logic [iad_pkg::IAD_PA_W-1:0]             parallel_port_a_upper_bits,
    output logic                                     isa_mode,
    output logic                                     mode_ready
);

    // ------------------------------------------------------------------
    // Parameter check
    // ------------------------------------------------------------------
    generate
        if (SD_W != iad_pkg::IAD_SD_W || SA_W != iad_pkg::IAD_SA_W || LA_W != iad_pkg::IAD_LA_W) begin : g_chk
            $error("iad_front supports only the documented pin widths");
        end
    endgenerate

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    iad_pkg::iad_ctl_t                 ctl_raw;
    iad_pkg::iad_ctl_t                 ctl_s;
    logic [iad_pkg::IAD_LA_W-1:0]      la_s;
    logic [iad_pkg::IAD_SA_W-1:0]      sa_s;
    logic [iad_pkg::IAD_SD_W-1:0]      sd_s;
    logic [iad_pkg::IAD_SYNC_W-1:0]    sync_q;

    assign ctl_raw = '{memr: ~memr_n, memw: ~memw_n, ior: ~ior_n, iow: ~iow_card_interface_strap_n,
                       aen: aen, ref_act: ~ref_n, bale: bale, sbhe: ~sbhe_n};

    // Address pins are only sampled here, never driven RULE3
    iad_sync #(
        .W (iad_pkg::IAD_SYNC_W)
    ) u_sync (
        .clk   (clk),
        .rst_n (rst_n),
        .d     ({ctl_raw, la_pin, sa_pin, sd_in}),
        .q     (sync_q)
    );

    assign {ctl_s, la_s, sa_s, sd_s} = sync_q;

    // ------------------------------------------------------------------
    // Mode strap
    // ------------------------------------------------------------------
    logic [1:0] strap_cnt_q;
    logic       strap_done_q;
    logic       isa_mode_q;
    wire        active = strap_done_q & isa_mode_q;

    // Waits for the synchroniser to fill before trusting the strap level
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            strap_cnt_q  <= 2'h0;
            strap_done_q <= 1'b0;
            isa_mode_q   <= 1'b0;
        end else if (!strap_done_q) begin
            strap_cnt_q <= strap_cnt_q + 2'h1;
            if (strap_cnt_q == iad_pkg::IAD_STRAP_WAIT) begin
                strap_done_q <= 1'b1;
                isa_mode_q   <= ~ctl_s.iow; // RULE1
            end
        end
    end

    // ------------------------------------------------------------------
    // Upper address latch and alternate pin functions
    // ------------------------------------------------------------------
    logic [iad_pkg::IAD_LA_W-1:0] la_lat_q;

    // Follows the lines while the enable is high, holds from its trailing edge
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            la_lat_q <= iad_pkg::IAD_LA_RST;
        end else if (ctl_s.bale) begin
            la_lat_q <= la_s; // RULE6
        end
    end

    wire ua_is_addr = (cfg_ua_mode == iad_pkg::IAD_UA_ADDR);
    wire [iad_pkg::IAD_ALT_W-1:0] ua_alt = ua_is_addr ? la_lat_q[iad_pkg::IAD_LA_W-1:iad_pkg::IAD_ALT_LSB]
                                                      : '0; // RULE5
    wire [iad_pkg::IAD_ADDR_W-1:0] bus_addr = {ua_alt, la_lat_q[iad_pkg::IAD_ALT_LSB-1:0], sa_s}; // RULE2

    assign external_interrupt_inputs = (cfg_ua_mode == iad_pkg::IAD_UA_IRQIN)
                                     ? la_s[iad_pkg::IAD_LA_W-1:iad_pkg::IAD_ALT_LSB] : '0; // RULE4
    assign parallel_port_a_upper_bits = (cfg_ua_mode == iad_pkg::IAD_UA_PORTA)
                                      ? la_s[iad_pkg::IAD_LA_W-1:iad_pkg::IAD_PA_LSB] : '0; // RULE4

    // ------------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------------
    function automatic logic in_window(input logic [iad_pkg::IAD_ADDR_W-1:0] a,
                                       input logic [iad_pkg::IAD_ADDR_W-1:0] base,
                                       input logic [iad_pkg::IAD_ADDR_W-1:0] mask);
        in_window = (((a ^ base) & mask) == '0);
    endfunction

    // Static lines are decoded live, relying on the master holding them RULE7
    wire mem_hit = in_window(bus_addr, cfg_mem_base, cfg_mem_mask);
    wire io_hit  = in_window({7'h00, sa_s}, {7'h00, cfg_io_base}, {7'h00, cfg_io_mask});
    wire mem_cmd = ctl_s.memr | ctl_s.memw;
    wire io_cmd  = ctl_s.ior | ctl_s.iow;
    wire sel     = active & ~ctl_s.aen & ((mem_cmd & mem_hit) | (io_cmd & io_hit)); // RULE13 RULE15
    wire rd_sel  = sel & (ctl_s.memr | ctl_s.ior);
    wire wr_sel  = sel & (ctl_s.memw | ctl_s.iow) & ~rd_sel;

    // 8-bit mode ignores high enable and always uses the low lane
    wire lane_lo = ~cfg_bus16 | ~sa_s[0]; // RULE11 RULE17
    wire lane_hi = cfg_bus16 & ctl_s.sbhe; // RULE12

    // ------------------------------------------------------------------
    // Cycle sequencer
    // ------------------------------------------------------------------
    iad_pkg::iad_state_t  state_q;
    iad_pkg::iad_state_t  state_d;
    iad_pkg::iad_access_t acc_q;
    iad_pkg::iad_access_t acc_d;
    logic                 acc_valid_q;
    logic                 acc_valid_d;

    always_comb begin
        state_d     = state_q;
        acc_d       = acc_q;
        acc_valid_d = 1'b0;
        case (state_q)
            iad_pkg::IAD_ST_IDLE: begin
                if (rd_sel) begin
                    state_d     = iad_pkg::IAD_ST_READ;
                    acc_valid_d = 1'b1;
                    acc_d       = '{addr: bus_addr, is_io: io_cmd, is_write: 1'b0,
                                    lane_lo: lane_lo, lane_hi: lane_hi, wdata: acc_q.wdata};
                end else if (wr_sel) begin
                    state_d = iad_pkg::IAD_ST_WRITE;
                    acc_d   = '{addr: bus_addr, is_io: io_cmd, is_write: 1'b1,
                                lane_lo: lane_lo, lane_hi: lane_hi, wdata: sd_s};
                end
            end
            iad_pkg::IAD_ST_READ: begin
                if (!rd_sel) begin
                    state_d = iad_pkg::IAD_ST_IDLE;
                end
            end
            iad_pkg::IAD_ST_WRITE: begin
                // Write data is taken at the command's trailing edge, when it is surely valid
                if (wr_sel) begin
                    acc_d.wdata = sd_s; // RULE9
                end else begin
                    state_d     = iad_pkg::IAD_ST_IDLE;
                    acc_valid_d = 1'b1;
                end
            end
            default: begin
                state_d = iad_pkg::IAD_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q     <= iad_pkg::IAD_ST_IDLE;
            acc_q       <= '0;
            acc_valid_q <= 1'b0;
        end else begin
            state_q     <= state_d;
            acc_q       <= acc_d;
            acc_valid_q <= acc_valid_d;
        end
    end

    // ------------------------------------------------------------------
    // Data lane drive and pin reuse
    // ------------------------------------------------------------------
    logic [iad_pkg::IAD_SD_W-1:0] sd_out_q;
    logic [iad_pkg::IAD_SD_W-1:0] sd_oe_q;
    logic                         iochrdy_oe_q;

    wire reading = (state_q == iad_pkg::IAD_ST_READ) & rd_sel & ~ctl_s.ref_act; // RULE9 RULE14
    wire [7:0] lo_byte = (!cfg_bus16 && sa_s[0]) ? core_rdata[15:8] : core_rdata[7:0]; // RULE11
    wire [7:0] oe_lo   = (reading & lane_lo) ? iad_pkg::IAD_LANE_ON : iad_pkg::IAD_LANE_OFF;
    wire [7:0] oe_hi_d = (reading & lane_hi) ? iad_pkg::IAD_LANE_ON : iad_pkg::IAD_LANE_OFF; // RULE8 RULE12
    // Free lines of the high lane become interrupt outputs only in 8-bit mode
    wire [7:0] oe_hi   = cfg_bus16 ? oe_hi_d : {5'h00, {iad_pkg::IAD_IRQ_W{active}}}; // RULE10
    wire [7:0] out_hi  = cfg_bus16 ? core_rdata[15:8] : {5'h00, host_irq_req}; // RULE10

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sd_out_q     <= iad_pkg::IAD_SD_RST;
            sd_oe_q      <= iad_pkg::IAD_SD_RST;
            iochrdy_oe_q <= 1'b0;
        end else begin
            sd_out_q     <= {out_hi, lo_byte};
            sd_oe_q      <= {oe_hi, oe_lo}; // RULE8
            iochrdy_oe_q <= sel & core_wait & (state_q != iad_pkg::IAD_ST_IDLE); // RULE16
        end
    end

    assign sd_out      = sd_out_q;
    assign sd_oe       = sd_oe_q;
    assign iochrdy_out = 1'b0;
    assign iochrdy_oe  = iochrdy_oe_q;
    assign acc         = acc_q;
    assign acc_valid   = acc_valid_q;
    assign isa_mode    = isa_mode_q;
    assign mode_ready  = strap_done_q;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    AST_STRAP_CAPTURE: assert property (@(posedge clk) disable iff (!rst_n) // RULE1
        $rose(strap_done_q) |-> isa_mode_q == !$past(ctl_s.iow))
        else $error("mode strap not captured from write pin");

    AST_NO_DRIVE_OFF_MODE: assert property (@(posedge clk) disable iff (!rst_n) // RULE1
        (!isa_mode_q && $past(!isa_mode_q)) |-> (sd_oe_q == '0 && !acc_valid_q))
        else $error("bus activity while host bus mode is off");

    AST_ADDR_FORM: assert property (@(posedge clk) disable iff (!rst_n) // RULE2
        (acc_valid_q && !acc_q.is_write) |-> acc_q.addr[16:0] == $past(sa_s))
        else $error("request address not formed from static lines");

    AST_ALT_ZERO: assert property (@(posedge clk) disable iff (!rst_n) // RULE5
        (acc_valid_q && !acc_q.is_write && $past(cfg_ua_mode) != iad_pkg::IAD_UA_ADDR) |-> acc_q.addr[23:19] == 5'h00)
        else $error("alternate function bits leaked into the address");

    AST_LA_HOLD: assert property (@(posedge clk) disable iff (!rst_n) // RULE6
        ($past(!ctl_s.bale) && $past(!ctl_s.bale, 2)) |-> $stable(la_lat_q))
        else $error("upper address changed while latch enable low");

    AST_LANE8: assert property (@(posedge clk) disable iff (!rst_n) // RULE8
        ($past(!cfg_bus16) && !cfg_bus16) |-> sd_oe_q[15:11] == 5'h00)
        else $error("high data lines driven in 8-bit mode");

    AST_OE_READ: assert property (@(posedge clk) disable iff (!rst_n) // RULE9
        (sd_oe_q[7:0] != 8'h00) |-> ($past(state_q) == iad_pkg::IAD_ST_READ && $past(rd_sel)))
        else $error("low data lane driven outside a read cycle");

    AST_AEN_GATE: assert property (@(posedge clk) disable iff (!rst_n) // RULE13
        (acc_valid_q && !acc_q.is_write) |-> $past(!ctl_s.aen))
        else $error("read served while address enable high");

    AST_REFRESH: assert property (@(posedge clk) disable iff (!rst_n) // RULE14
        $past(ctl_s.ref_act) |-> (sd_oe_q[7:0] == 8'h00 && (!$past(cfg_bus16) || sd_oe_q[15:8] == 8'h00)))
        else $error("data bus driven during refresh");

    AST_HI_LANE: assert property (@(posedge clk) disable iff (!rst_n) // RULE12
        ($past(cfg_bus16) && sd_oe_q[15]) |-> $past(ctl_s.sbhe))
        else $error("high lane driven without high enable");

    AST_WAIT: assert property (@(posedge clk) disable iff (!rst_n) // RULE16
        (state_q == iad_pkg::IAD_ST_READ && rd_sel && core_wait) |=> iochrdy_oe_q)
        else $error("channel ready not pulled low for wait");

    AST_WRITE_END: assert property (@(posedge clk) disable iff (!rst_n) // RULE15
        (state_q == iad_pkg::IAD_ST_WRITE && !wr_sel) |=> (acc_valid_q && acc_q.is_write))
        else $error("write not reported at command end");

    COV_READ16: cover property (@(posedge clk) disable iff (!rst_n)
        cfg_bus16 && sd_oe_q == 16'hFFFF);
    COV_WRITE: cover property (@(posedge clk) disable iff (!rst_n)
        acc_valid_q && acc_q.is_write);
    COV_WAIT: cover property (@(posedge clk) disable iff (!rst_n)
        iochrdy_oe_q ##1 !iochrdy_oe_q);
    COV_IRQ8: cover property (@(posedge clk) disable iff (!rst_n)
        !cfg_bus16 && sd_oe_q[10:8] == 3'h7 && sd_out_q[10:8] != 3'h0);

endmodule

// File: iad_pkg.sv
// Constants, types and carriers for the expansion-bus address/data pin front end.
// Assumes every user writes iad_pkg::name; nothing is imported.
package iad_pkg;

    // ------------------------------------------------------------------
    // Widths and field positions
    // ------------------------------------------------------------------
    localparam int IAD_LA_W    = 7;
    localparam int IAD_SA_W    = 17;
    localparam int IAD_ADDR_W  = 24;
    localparam int IAD_SD_W    = 16;
    localparam int IAD_ALT_LSB = 2;
    localparam int IAD_ALT_W   = 5;
    localparam int IAD_PA_LSB  = 3;
    localparam int IAD_PA_W    = 4;
    localparam int IAD_IRQ_W   = 3;
    localparam int IAD_IRQ_LSB = 8;
    localparam int IAD_CTL_W   = 8;
    localparam int IAD_SYNC_W  = IAD_CTL_W + IAD_LA_W + IAD_SA_W + IAD_SD_W;

    // ------------------------------------------------------------------
    // Reset values and timing counts
    // ------------------------------------------------------------------
    localparam logic [1:0]  IAD_STRAP_WAIT = 2'h2;
    localparam logic [15:0] IAD_SD_RST     = 16'h0000;
    localparam logic [6:0]  IAD_LA_RST     = 7'h00;
    localparam logic [7:0]  IAD_LANE_ON    = 8'hFF;
    localparam logic [7:0]  IAD_LANE_OFF   = 8'h00;

    // ------------------------------------------------------------------
    // Enumerations
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        IAD_UA_ADDR  = 3'b001,
        IAD_UA_IRQIN = 3'b010,
        IAD_UA_PORTA = 3'b100
    } iad_ua_mode_t;

    typedef enum logic [2:0] {
        IAD_ST_IDLE  = 3'b001,
        IAD_ST_READ  = 3'b010,
        IAD_ST_WRITE = 3'b100
    } iad_state_t;

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic memr;
        logic memw;
        logic ior;
        logic iow;
        logic aen;
        logic ref_act;
        logic bale;
        logic sbhe;
    } iad_ctl_t;

    typedef struct packed {
        logic [IAD_ADDR_W-1:0] addr;
        logic                  is_io;
        logic                  is_write;
        logic                  lane_lo;
        logic                  lane_hi;
        logic [IAD_SD_W-1:0]   wdata;
    } iad_access_t;

endpackage

// File: iad_sync.sv
// Two-flop synchroniser for a vector of asynchronous pin levels.
// Assumes levels change slowly compared to clk; no pulse shorter than two cycles.
module iad_sync #(
    parameter int W = 8
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_q;

    generate
        if (W < 1) begin : g_chk
            $error("iad_sync width must be positive");
        end
    endgenerate

    // First stage feeds only the second stage
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= '0;
            q      <= '0;
        end else begin
            meta_q <= d;
            q      <= meta_q;
        end
    end
endmodule

// File: iad_isa_master.sv
// Behavioural expansion-bus master that drives the pins of the address/data front end.
// Assumes the bench calls its tasks from a single process and resolves sd_in itself.
module iad_isa_master (
    input  wire logic        clk,
    output logic      [6:0]  la_pin,
    output logic      [16:0] sa_pin,
    output logic      [15:0] sd_m,
    output logic             bale,
    output logic             aen,
    output logic             sbhe_n,
    output logic             memr_n,
    output logic             memw_n,
    output logic             ior_n,
    output logic             iow_n,
    output logic             ref_n
);
    timeunit 1ns;
    timeprecision 1ps;
    logic        wr_act = 1'b0;
    logic [15:0] wd_q   = 16'h0000;
    logic [15:0] pat_q  = 16'h5A5A;
    initial begin
        {la_pin, sa_pin, bale, aen} = '0;
        {sbhe_n, memr_n, memw_n, ior_n, iow_n, ref_n} = 6'h3F;
    end
    // Released data lines show a changing pattern, never the last value
    assign sd_m = wr_act ? wd_q : pat_q;
    always @(negedge clk) pat_q <= ~pat_q;
    task automatic set_strap(input logic v);
        iow_n = v;
    endtask
    task automatic start(input logic wr, input logic io, input logic [23:0] a,
                         input logic sb, input logic av, input logic rv, input logic [15:0] wd);
        @(negedge clk);
        la_pin = a[23:17];
        sa_pin = a[16:0];
        {sbhe_n, aen, ref_n, bale} = {sb, av, rv, 1'b1};
        repeat (2) @(negedge clk);
        bale = 1'b0;
        @(negedge clk);
        la_pin = ~a[23:17];
        {wr_act, wd_q} = {wr, wd};
        {memr_n, memw_n, ior_n, iow_n} = ~{~wr & ~io, wr & ~io, ~wr & io, wr & io};
    endtask
    task automatic stop();
        @(negedge clk);
        {memr_n, memw_n, ior_n, iow_n, wr_act} = 5'h1E;
        {aen, ref_n} = 2'b01;
        @(negedge clk);
        sa_pin = ~sa_pin;
    endtask
endmodule

// File: tb.sv
// Self-checking bench for the address/data pin front end, master model on the pins.
// Assumes iad_front and iad_isa_master are compiled before it.
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic b16; logic io; logic [23:0] a; logic sb; logic av; logic rv; logic hit;
    } iad_row_t;
    logic                  clk = 1'b0;
    logic                  rst_n = 1'b0;
    logic                  b16 = 1'b1;
    logic                  wt = 1'b0;
    logic [2:0]            irq = 3'h5;
    logic [15:0]           rdat = 16'hC3A5;
    logic                  got;
    logic [23:0]           mmask = 24'hFF0000;
    iad_pkg::iad_ua_mode_t ua = iad_pkg::IAD_UA_ADDR;
    logic [6:0]            la;
    logic [16:0]           sa;
    logic [15:0]           sd_m, sd_out, sd_oe, sd_in;
    logic                  bale, aen, sbhe_n, memr_n, memw_n, ior_n, iow_n, ref_n;
    logic                  rdy_o, rdy_oe, acc_valid, isa_mode, mode_ready;
    logic [4:0]            ext_irq;
    logic [3:0]            pa;
    iad_pkg::iad_access_t  acc;
    int                    num_errors = 0;
    int                    cmp_count = 0;
    iad_row_t rows [11] = '{'{1,0,24'hD01230,0,0,1,1}, '{1,0,24'hD01231,0,0,1,1}, '{1,0,24'hD01232,1,0,1,1},
        '{0,0,24'hD01234,0,0,1,1}, '{0,0,24'hD01235,1,0,1,1}, '{1,1,24'h000304,0,0,1,1},
        '{0,1,24'h000301,1,0,1,1}, '{1,0,24'hD01230,0,1,1,0}, '{1,0,24'hC01230,0,0,1,0},
        '{1,0,24'hD01230,0,0,0,1}, '{1,1,24'h000404,0,0,1,0}};
    always #5 clk = ~clk;
    // Wire level: the device wins where it drives, the master elsewhere
    assign sd_in = (sd_out & sd_oe) | (sd_m & ~sd_oe);
    iad_isa_master pm (.clk(clk), .la_pin(la), .sa_pin(sa), .sd_m(sd_m), .bale(bale), .aen(aen),
        .sbhe_n(sbhe_n), .memr_n(memr_n), .memw_n(memw_n), .ior_n(ior_n), .iow_n(iow_n), .ref_n(ref_n));
    iad_front dut (.clk(clk), .rst_n(rst_n), .la_pin(la), .sa_pin(sa), .sd_in(sd_in), .sd_out(sd_out),
        .sd_oe(sd_oe), .bale(bale), .aen(aen), .sbhe_n(sbhe_n), .memr_n(memr_n), .memw_n(memw_n),
        .ior_n(ior_n), .iow_card_interface_strap_n(iow_n), .ref_n(ref_n), .iochrdy_out(rdy_o),
        .iochrdy_oe(rdy_oe), .cfg_bus16(b16), .cfg_ua_mode(ua), .cfg_mem_base(24'hD00000),
        .cfg_mem_mask(mmask), .cfg_io_base(17'h00300), .cfg_io_mask(17'h1FFF0), .host_irq_req(irq),
        .core_wait(wt), .core_rdata(rdat), .acc(acc), .acc_valid(acc_valid),
        .external_interrupt_inputs(ext_irq), .parallel_port_a_upper_bits(pa), .isa_mode(isa_mode),
        .mode_ready(mode_ready));
    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic cmp(input logic [23:0] g, input logic [23:0] e);
        cmp_count++;
        if (g !== e) begin
            num_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    // The pulse lasts one cycle, so it is latched over a fixed span
    task automatic wait_acc();
        got = 1'b0;
        repeat (8) begin
            @(negedge clk);
            if (acc_valid === 1'b1) got = 1'b1;
        end
    endtask
    task automatic read_row(input iad_row_t r);
        logic        lo, hi;
        logic [15:0] eoe, eout;
        lo = r.b16 ? ~r.a[0] : 1'b1;
        hi = r.b16 & ~r.sb;
        eoe = (r.hit & ~r.av & r.rv) ? {{8{hi}}, {8{lo}}} : 16'h0000;
        eout = {8'hC3, (~r.b16 & r.a[0]) ? 8'hC3 : 8'hA5};
        // Interrupt codes track the address bits so a swapped bit order shows up where the code is 3 or 6
        irq = r.a[2:0] ^ 3'h2;
        if (!r.b16) begin
            eoe[10:8] = 3'h7;
            eout[10:8] = irq;
        end
        b16 = r.b16;
        wt = r.sb;
        pm.start(1'b0, r.io, r.a, r.sb, r.av, r.rv, 16'h0000);
        wait_acc();
        if (r.rv) cmp({23'h0, got}, {23'h0, r.hit & ~r.av});
        if (got && r.rv) begin
            cmp(r.io ? {7'h0, acc.addr[16:0]} : acc.addr, r.io ? {7'h0, r.a[16:0]} : r.a);
            cmp({20'h0, acc.lane_hi, acc.lane_lo, acc.is_io, acc.is_write}, {20'h0, hi, lo, r.io, 1'b0});
        end
        cmp({8'h0, sd_oe}, {8'h0, eoe});
        cmp({23'h0, rdy_oe}, {23'h0, r.hit & ~r.av & r.sb});
        cmp({8'h0, sd_out & eoe}, {8'h0, eout & eoe});
        pm.stop();
        repeat (3) @(negedge clk);
        cmp({8'h0, sd_oe & 16'hF8FF}, 24'h0);
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        #50000;
        num_errors++;
        end_sim();
    end
    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (5) @(negedge clk);
        cmp({6'h0, sd_oe, acc_valid, rdy_oe}, 24'h0);
        rst_n = 1'b1;
        repeat (5) @(negedge clk);
        cmp({22'h0, isa_mode, mode_ready}, 24'h3);
        $display("test reset done");
        foreach (rows[i]) begin
            read_row(rows[i]);
            $display("test read row %0d done", i);
        end
        b16 = 1'b1;
        pm.start(1'b1, 1'b0, 24'hD00100, 1'b0, 1'b0, 1'b1, 16'h5AA5);
        wt = 1'b1;
        repeat (4) @(negedge clk);
        cmp({7'h0, sd_oe, rdy_oe, rdy_o}, 24'h2);
        wt = 1'b0;
        repeat (3) @(negedge clk);
        cmp({23'h0, rdy_oe}, 24'h0);
        pm.stop();
        wait_acc();
        cmp({7'h0, got, acc.wdata}, 24'h015AA5);
        cmp(acc.addr, 24'hD00100);
        cmp({21'h0, acc.is_write, acc.lane_hi, acc.lane_lo}, 24'h7);
        b16 = 1'b0;
        pm.start(1'b1, 1'b1, 24'h000302, 1'b1, 1'b0, 1'b1, 16'h3C96);
        repeat (3) @(negedge clk);
        pm.stop();
        wait_acc();
        cmp({15'h0, got, acc.wdata[7:0]}, 24'h196);
        cmp({7'h0, acc.addr[16:0]}, 24'h000302);
        cmp({20'h0, acc.is_io, acc.is_write, acc.lane_hi, acc.lane_lo}, 24'hD);
        b16 = 1'b1;
        $display("test write done");
        ua = iad_pkg::IAD_UA_IRQIN;
        mmask = 24'h000000;
        pm.start(1'b0, 1'b0, 24'hAA0010, 1'b0, 1'b0, 1'b1, 16'h0000);
        wait_acc();
        cmp(acc.addr, 24'h020010);
        pm.stop();
        repeat (4) @(negedge clk);
        cmp({19'h0, ext_irq}, 24'h0A);
        ua = iad_pkg::IAD_UA_PORTA;
        repeat (4) @(negedge clk);
        cmp({15'h0, ext_irq, pa}, 24'h5);
        {ua, mmask} = {iad_pkg::IAD_UA_ADDR, 24'hFF0000};
        $display("test pin reuse done");
        pm.set_strap(1'b0);
        rst_n = 1'b0;
        repeat (5) @(negedge clk);
        rst_n = 1'b1;
        repeat (5) @(negedge clk);
        cmp({22'h0, isa_mode, mode_ready}, 24'h1);
        pm.start(1'b0, 1'b0, 24'hD01230, 1'b0, 1'b0, 1'b1, 16'h0000);
        wait_acc();
        cmp({7'h0, got, sd_oe}, 24'h0);
        pm.stop();
        $display("test strap low done");
        end_sim();
    end
endmodule
